// *** verilog/ppwm_params.svh ***
/*
  Register offsets, field positions, reset values and timing counts of the pulse period/width meter.
  Assumes nothing; definitions only.
*/
`ifndef PPWM_PARAMS_SVH
`define PPWM_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PPWM_OFS_MODE 12'h000
`define PPWM_OFS_START 12'h004
`define PPWM_OFS_TIMER 12'h008
`define PPWM_OFS_STATUS 12'h00C
`define PPWM_OFS_IRQ_STAT 12'h010
`define PPWM_OFS_IRQ_MASK 12'h014
`define PPWM_OFS_COUNT 12'h018

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define PPWM_MODE_OP_LSB 0
`define PPWM_MODE_OP_MSB 1
`define PPWM_MODE_SRC_LSB 2
`define PPWM_MODE_SRC_MSB 3
`define PPWM_MODE_FUNC_BIT 4
`define PPWM_MODE_POL_BIT 5
`define PPWM_MODE_RESET 6'h00
`define PPWM_MODE_MEASURE 2'h2

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define PPWM_IRQ_EDGE_BIT 0
`define PPWM_IRQ_OVF_BIT 1

// ----------------------------------------
// Prescaler
// ----------------------------------------
`define PPWM_DIV_EIGHT 5'h07
`define PPWM_DIV_THIRTYTWO 5'h1F

`endif

// *** verilog/ppwm_pkg.sv ***
/*
  Types of the pulse period/width meter.
  Assumes nothing; types only.
*/
package ppwm_pkg;

  typedef enum logic [1:0] {
    PPWM_SRC_UNDIV = 2'b00,
    PPWM_SRC_DIV8 = 2'b01,
    PPWM_SRC_DIV32 = 2'b10,
    PPWM_SRC_SUB32 = 2'b11
  } ppwm_src_e;

  typedef enum logic [1:0] {
    PPWM_MS_IDLE = 2'b00,
    PPWM_MS_FIRST = 2'b01,
    PPWM_MS_RUN = 2'b10
  } ppwm_meas_e;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
  } ppwm_req_s;

endpackage

// *** verilog/ppwm_meter.sv ***
/*
  One measure_timer_channel in pulse period / pulse width measurement mode, with AHB-Lite register slave.
  Assumes a 125 MHz hclk, an asynchronous measure_pulse_input pin and a free-running sub clock tick input.
*/
// Contract
// - Period or width measurement selectable
// - Up count from four selectable sources
// - Valid edge: capture count, clear, continue
// - Start flag one starts counting
// - Start flag zero halts counting
// - Valid edge raises interrupt request
// - No interrupt on first edge after start
// - Overflow raises interrupt and sets flag
// - Mode write while started clears overflow
// - Timer read returns reload register
// - Timer writes ignored in measurement mode
// - Result indeterminate before second edge
// - Mode register bits 0-1 choose mode
`timescale 1ns/1ps
`include "ppwm_params.svh"

module ppwm_meter (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Measurement pin and sub clock tick
  input wire logic measure_pulse_input,
  input wire logic sub_clock_tick,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  ppwm_pkg::ppwm_req_s req;
  logic req_valid;
  wire addr_take = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_valid <= 1'b0;
      req <= '0;
    end else begin
      req_valid <= addr_take;
      if (addr_take) begin
        req.addr <= haddr[11:0];
        req.write <= hwrite;
      end
    end
  end

  wire wr = req_valid & req.write;
  wire rd = req_valid & ~req.write;
  wire wr_mode = wr & (req.addr == `PPWM_OFS_MODE);
  wire wr_start = wr & (req.addr == `PPWM_OFS_START);
  wire wr_istat = wr & (req.addr == `PPWM_OFS_IRQ_STAT);
  wire wr_imask = wr & (req.addr == `PPWM_OFS_IRQ_MASK);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [5:0] mode;
  logic start;
  logic [1:0] irq_mask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= `PPWM_MODE_RESET;
      start <= 1'b0;
      irq_mask <= 2'h0;
    end else begin
      if (wr_mode)
        mode <= hwdata[5:0];
      if (wr_start)
        start <= hwdata[0];
      if (wr_imask)
        irq_mask <= hwdata[1:0];
    end
  end

  wire measure_mode = (mode[`PPWM_MODE_OP_MSB:`PPWM_MODE_OP_LSB] == `PPWM_MODE_MEASURE);
  wire width_sel = mode[`PPWM_MODE_FUNC_BIT];
  wire edge_pol = mode[`PPWM_MODE_POL_BIT];
  wire ppwm_pkg::ppwm_src_e src = ppwm_pkg::ppwm_src_e'(mode[`PPWM_MODE_SRC_MSB:`PPWM_MODE_SRC_LSB]);
  wire running = start & measure_mode;

  // ----------------------------------------
  // Prescaler and count tick
  // ----------------------------------------
  logic [4:0] pre;
  logic [4:0] sub_pre;
  logic [2:0] sub_sync;
  wire sub_rise;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre <= 5'h00;
      sub_pre <= 5'h00;
      sub_sync <= 3'h0;
    end else begin
      pre <= pre + 5'h01;
      sub_sync <= {sub_sync[1:0], sub_clock_tick};
      if (sub_rise)
        sub_pre <= sub_pre + 5'h01;
    end
  end

  // Sub clock is slow and foreign, so its edges are synchronised first
  assign sub_rise = (sub_sync[2:1] == 2'b01);
  logic tick;
  always_comb begin
    unique case (src)
      ppwm_pkg::PPWM_SRC_UNDIV: tick = 1'b1;
      ppwm_pkg::PPWM_SRC_DIV8: tick = (pre[2:0] == `PPWM_DIV_EIGHT);
      ppwm_pkg::PPWM_SRC_DIV32: tick = (pre == `PPWM_DIV_THIRTYTWO);
      ppwm_pkg::PPWM_SRC_SUB32: tick = sub_rise & (sub_pre == `PPWM_DIV_THIRTYTWO);
    endcase
  end

  // ----------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------
  logic [2:0] pin_sync;
  logic pin_level;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync <= 3'h0;
      pin_level <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], measure_pulse_input};
      if (pin_sync[2] == pin_sync[1])
        pin_level <= pin_sync[2];
    end
  end

  // Level changes only once two stages agree
  wire change = (pin_sync[2] == pin_sync[1]) & (pin_sync[2] != pin_level);
  wire rise = change & pin_sync[2];
  wire fall = change & ~pin_sync[2];
  wire pol_edge = edge_pol ? fall : rise;
  wire valid_edge = running & (width_sel ? (rise | fall) : pol_edge);

  // ----------------------------------------
  // Counter, reload register, first edge tracking
  // ----------------------------------------
  logic [15:0] count;
  logic [15:0] reload;
  ppwm_pkg::ppwm_meas_e mstate;
  ppwm_pkg::ppwm_meas_e next_mstate;
  wire count_step = running & tick;
  wire overflow = count_step & ~valid_edge & (count == 16'hFFFF);

  always_comb begin
    next_mstate = mstate;
    unique case (mstate)
      ppwm_pkg::PPWM_MS_IDLE: if (running) next_mstate = ppwm_pkg::PPWM_MS_FIRST;
      ppwm_pkg::PPWM_MS_FIRST: if (valid_edge) next_mstate = ppwm_pkg::PPWM_MS_RUN;
      ppwm_pkg::PPWM_MS_RUN: next_mstate = ppwm_pkg::PPWM_MS_RUN;
      default: next_mstate = ppwm_pkg::PPWM_MS_IDLE;
    endcase
    if (!running)
      next_mstate = ppwm_pkg::PPWM_MS_IDLE;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 16'h0000;
      reload <= 16'h0000;
      mstate <= ppwm_pkg::PPWM_MS_IDLE;
    end else begin
      mstate <= next_mstate;
      // Timer register writes never reach count or reload
      if (valid_edge) begin
        reload <= count;
        count <= 16'h0000;
      end else if (count_step) begin
        count <= count + 16'h0001;
      end
    end
  end

  // First edge after start is only a reference point
  wire edge_irq = valid_edge & (mstate == ppwm_pkg::PPWM_MS_RUN);

  // ----------------------------------------
  // Overflow flag and interrupt status
  // ----------------------------------------
  logic ovf_flag;
  logic [1:0] irq_stat;
  wire [1:0] irq_set = {overflow, edge_irq};
  wire [1:0] irq_clr = wr_istat ? hwdata[1:0] : 2'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_flag <= 1'b0;
      irq_stat <= 2'h0;
    end else begin
      // Set wins over a same-cycle clear
      if (overflow)
        ovf_flag <= 1'b1;
      else if (wr_mode & start)
        ovf_flag <= 1'b0;
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------
  // Read data and response
  // ----------------------------------------
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (req.addr)
      `PPWM_OFS_MODE: next_rdata = {26'h0, mode};
      `PPWM_OFS_START: next_rdata = {31'h0, start};
      `PPWM_OFS_TIMER: next_rdata = {16'h0000, reload};
      `PPWM_OFS_STATUS: next_rdata = {30'h0, mstate == ppwm_pkg::PPWM_MS_RUN, ovf_flag};
      `PPWM_OFS_IRQ_STAT: next_rdata = {30'h0, irq_stat};
      `PPWM_OFS_IRQ_MASK: next_rdata = {30'h0, irq_mask};
      `PPWM_OFS_COUNT: next_rdata = {16'h0000, count};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Read data registered so hrdata holds the last read value between reads
  logic [31:0] rdata_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rdata_q <= 32'h00000000;
    else if (rd)
      rdata_q <= next_rdata;
  end

  // hrdata valid in the data phase: combinational from registered state
  assign hrdata = rd ? next_rdata : rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule // ppwm_meter

// *** verif/ppwm_meter_asserts.sv ***
/* Bus and irq checks of the meter.
   Assumes a bind to ppwm_meter. */
`timescale 1ns/1ps
module ppwm_meter_asserts (
  // Clock, reset, bus, irq
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq
);
  logic rd_dp;
  logic wr_dp;
  logic [11:0] a_q;
  wire take = hready & htrans[1];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp <= 1'b0;
      wr_dp <= 1'b0;
      a_q <= 12'h000;
    end else begin
      rd_dp <= take & ~hwrite;
      wr_dp <= take & hwrite;
      a_q <= take ? haddr[11:0] : a_q;
    end
  end
  property p_rdy; hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state");
  property p_ok; !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bad response");
  property p_up; rd_dp |-> hrdata[31:16] == 16'h0; endproperty
  a_up: assert property (p_up) else $error("upper bits");
  property p_un; rd_dp && a_q > 12'h018 |-> hrdata == 32'h0; endproperty
  a_un: assert property (p_un) else $error("unmapped read");
  property p_md; rd_dp && a_q == 12'h000 |-> hrdata[31:6] == 26'h0; endproperty
  a_md: assert property (p_md) else $error("mode bits");
  property p_st; rd_dp && a_q == 12'h00C |-> hrdata[31:2] == 30'h0; endproperty
  a_st: assert property (p_st) else $error("status bits");
  property p_hold; !rd_dp |-> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_fall; $fell(irq) |-> $past(wr_dp); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped alone");
  c_irq: cover property ($rose(irq));
  c_tmr: cover property (rd_dp && a_q == 12'h008);
  c_md: cover property (wr_dp && a_q == 12'h000);
endmodule // ppwm_meter_asserts
bind ppwm_meter ppwm_meter_asserts u_asserts (.hclk, .hresetn, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .irq);

// *** verif/ppwm_pulse_src.sv ***
/* Pulse source on the measurement pin and a free sub clock.
   Assumes hclk from the bench. */
`timescale 1ns/1ps
module ppwm_pulse_src (
  // Clock
  input wire logic hclk,
  // Pins
  output logic measure_pulse_input,
  output logic sub_clock_tick
);
  // Sub clock offset so its edges never meet hclk edges
  initial begin
    measure_pulse_input = 1'b0;
    sub_clock_tick = 1'b0;
    #3;
    forever #64 sub_clock_tick = ~sub_clock_tick;
  end
  task automatic pulse(input int hi, input int lo);
    @(posedge hclk);
    measure_pulse_input <= 1'b1;
    repeat (hi) @(posedge hclk);
    measure_pulse_input <= 1'b0;
    repeat (lo) @(posedge hclk);
  endtask
endmodule // ppwm_pulse_src

// *** verif/pulse_period_width_meter_tb_top.sv ***
/* Bench of the meter over AHB-Lite.
   Assumes the meter, its checker and the pulse source. */
`timescale 1ns/1ps
module pulse_period_width_meter_tb_top;
  logic hclk, hresetn, hwrite, hready, hreadyout, hresp, irq, pin, tick;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [15:0] a;
  int fails, comparisons, cyc;
  int sh[4] = '{0, 3, 5, 9};
  assign hready = hreadyout;
  ppwm_meter DUT (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .measure_pulse_input(pin), .sub_clock_tick(tick), .irq);
  ppwm_pulse_src src (.hclk, .measure_pulse_input(pin), .sub_clock_tick(tick));
  task automatic xf(input logic [11:0] ad, input logic w, input logic [31:0] d);
    haddr <= {20'h0, ad};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    v = hrdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [11:0] ad, input logic [31:0] e);
    xf(ad, 1'b0, 32'h0);
    chk(v, e);
  endtask
  // One read per pulse and the pulse task's first wait add the same 3 cycles to every period
  task automatic pr(input int hi, input int lo, input logic [11:0] ad);
    src.pulse(hi, lo);
    xf(ad, 1'b0, 32'h0);
  endtask
  task automatic dl(input logic [11:0] ad, input int n);
    xf(ad, 1'b0, 32'h0);
    a = v[15:0];
    repeat (n) @(posedge hclk);
    xf(ad, 1'b0, 32'h0);
    v = {16'h0, v[15:0] - a};
  endtask
  task automatic stop_test;
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    {hresetn, htrans, hwrite, haddr, hwdata} = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rc(12'h000, 32'h0);
    rc(12'h014, 32'h0);
    xf(12'h01C, 1'b1, 32'hFFFF);
    rc(12'h01C, 32'h0);
    xf(12'h014, 1'b1, 32'h3);
    xf(12'h000, 1'b1, 32'h2);
    xf(12'h004, 1'b1, 32'h1);
    pr(20, 19, 12'h010);
    chk(v, 32'h0);
    pr(20, 19, 12'h010);
    chk(v, 32'h1);
    chk({31'h0, irq}, 32'h1);
    pr(30, 29, 12'h008);
    a = v[15:0];
    pr(20, 19, 12'h008);
    chk({16'h0, v[15:0] - a}, 32'h14);
    xf(12'h000, 1'b1, 32'h12);
    pr(20, 60, 12'h008);
    pr(20, 60, 12'h008);
    a = v[15:0];
    pr(50, 30, 12'h008);
    chk({16'h0, v[15:0] - a}, 32'h1E);
    for (int s = 0; s < 4; s++) begin
      xf(12'h000, 1'b1, {26'h0, s[1:0], 2'h2});
      dl(12'h018, 1022);
      chk(v, 32'h400 >> sh[s]);
    end
    xf(12'h000, 1'b1, 32'h0);
    dl(12'h018, 100);
    chk(v, 32'h0);
    xf(12'h000, 1'b1, 32'h2);
    xf(12'h004, 1'b1, 32'h0);
    dl(12'h018, 100);
    chk(v, 32'h0);
    xf(12'h008, 1'b0, 32'h0);
    a = v[15:0];
    xf(12'h008, 1'b1, 32'h1234);
    rc(12'h008, {16'h0, a});
    xf(12'h010, 1'b1, 32'h3);
    xf(12'h004, 1'b1, 32'h1);
    repeat (65600) @(posedge hclk);
    xf(12'h00C, 1'b0, 32'h0);
    chk({31'h0, v[0]}, 32'h1);
    rc(12'h010, 32'h2);
    xf(12'h014, 1'b1, 32'h1);
    @(negedge hclk);
    chk({31'h0, irq}, 32'h0);
    xf(12'h000, 1'b1, 32'h2);
    xf(12'h00C, 1'b0, 32'h0);
    chk({31'h0, v[0]}, 32'h0);
    xf(12'h010, 1'b1, 32'h3);
    rc(12'h010, 32'h0);
    stop_test();
  end
endmodule // pulse_period_width_meter_tb_top
